// ==== design/scc_device_end.sv ====
`timescale 1ns/1ps
`default_nettype none
module scc_device_end
  import scc_pkg::*;
#(
  parameter int SRC_NUM = 8
) (
  scc_link_if.dev          link,              // Serial link
  input  wire logic        rst,               // Sync to link clock
  input  wire logic        crcSel,            // Three-bit check select
  input  wire logic [2:0]  crcSeedField,      // Check seed
  input  wire logic        initDoneFlag,      // Initialisation done
  input  wire logic        selfTestActive,    // Self-test running
  input  wire logic        internalError,     // Internal error present
  input  wire logic        sampleValid,       // Sample usable
  input  wire logic [1:0]  detailStatusField, // Detail status
  input  wire logic [15:0] sampleField,       // Sample plus extra bits
  input  wire logic [15:0] regRdData,         // Register read value
  output logic             regReqTgl,         // Toggles per reg command with a good check
  output logic [3:0]       regCmd,            // Taken command code
  output logic [7:0]       regAddrField,      // Taken register address
  output logic [7:0]       regWrData          // Taken register data
);

  ////////////////////////////////////////////////////////////
  // Input crossing onto the link clock
  ////////////////////////////////////////////////////////////
  // Slow quasi-static levels; they settle within the first link
  // edges of a frame, well before the answer is built at its end.
  localparam int SYW = 42;

  logic [SYW-1:0] syncA_ff;
  logic [SYW-1:0] syncB_ff;

  always_ff @(posedge link.sclk) begin
    if (rst) begin
      syncA_ff <= '0;
      syncB_ff <= '0;
    end else begin
      syncA_ff <= {crcSel, crcSeedField, initDoneFlag, selfTestActive,
                   internalError, sampleValid, detailStatusField,
                   sampleField, regRdData};
      syncB_ff <= syncA_ff;
    end
  end

  logic        selS;
  logic [2:0]  seedS;
  logic        initS;
  logic        selfS;
  logic        errS;
  logic        validS;
  logic [1:0]  detailS;
  logic [15:0] sampleS;
  logic [15:0] regRdS;

  assign {selS, seedS, initS, selfS, errS, validS, detailS,
          sampleS, regRdS} = syncB_ff;

  ////////////////////////////////////////////////////////////
  // Receive shift and running check
  ////////////////////////////////////////////////////////////
  logic [CNT_W-1:0] bitCnt_ff;
  logic [31:0]      rxSr_ff;
  logic [2:0]       crcChk_ff;
  logic [2:0]       crcCur;
  logic [2:0]       nxt_crcChk;
  logic [2:0]       seedRes;
  logic [31:0]      rxWord;
  logic             active;
  logic             fire;

  assign active     = !link.csN && selS;
  assign crcCur     = (bitCnt_ff == '0) ? CRC_ZERO : crcChk_ff;
  // Seed term folded in at the end, the check being linear: the seed
  // crosses on link edges and only settles after the first two of a frame.
  assign seedRes    = crc3Word(seedS, '0);
  assign nxt_crcChk = crc3Step(crcCur, link.mosi);
  assign rxWord     = {rxSr_ff[30:0], link.mosi};
  assign fire       = active && (bitCnt_ff == LAST_BIT);

  // A frame is exactly 32 link edges; a short frame leaves the
  // counter mid-word, so the host must never abort one.
  always_ff @(posedge link.sclk) begin
    if (rst) begin
      bitCnt_ff <= '0;
      rxSr_ff   <= '0;
      crcChk_ff <= CRC_ZERO;
    end else if (!link.csN) begin
      // Counts every frame so the bit position never hangs on the
      // synced mode bit, which lags the first edges of a frame.
      bitCnt_ff <= bitCnt_ff + 5'h1;
      rxSr_ff   <= rxWord;
      crcChk_ff <= nxt_crcChk;
    end
  end

  ////////////////////////////////////////////////////////////
  // Command decode and answer build
  ////////////////////////////////////////////////////////////
  logic [3:0]       cmd;
  logic [3:0]       echo;
  logic             crcOk;
  logic             isSensor;
  logic [SRC_W-1:0] src;
  logic [1:0]       status;
  logic             noSample;
  logic [31:0]      errWord;
  logic [31:0]      body;
  logic [31:0]      resp;
  logic [3:0]       msgCnt_ff [SRC_NUM];

  assign cmd      = rxWord[CMD_MSB:CMD_LSB];
  assign echo     = {cmd[0], cmd[3:1]};
  assign crcOk    = ((nxt_crcChk ^ seedRes) == CRC_ZERO);
  assign isSensor = cmd[CMD_SENSOR];
  assign src      = cmd[3:1];
  assign status   = coarseStatus(initS, selfS, errS);
  assign noSample = errS && !validS;
  assign errWord  = {CMD_NONE, ST_ERROR, 1'b0, 15'h0000,
                     detailS, 5'h00, CRC_ZERO};

  always_comb begin
    if (!crcOk) begin
      body = errWord;
    end else if (isSensor && noSample) begin
      body = errWord;
    end else if (isSensor) begin
      body = {echo, status, sampleS, detailS,
              msgCnt_ff[src], 1'b1, CRC_ZERO};
    end else if (errS) begin
      body = {CMD_NONE, ST_ERROR, 2'h0, regRdS, 5'h00, CRC_ZERO};
    end else begin
      body = {echo, status, 2'h0, regRdS, 5'h00, CRC_ZERO};
    end
  end

  // Check field is zero in body, so this is message plus three zeros
  assign resp = {body[31:3], crc3Word(seedS, body)};

  ////////////////////////////////////////////////////////////
  // Answer shift, one frame late
  ////////////////////////////////////////////////////////////
  logic [31:0] txSr_ff;

  always_ff @(posedge link.sclk) begin
    if (rst) begin
      txSr_ff <= RESP_RST;
    end else if (fire) begin
      txSr_ff <= resp;
    end
  end

  // Bit changes just after the rising edge, so the host sees it
  // stable for a whole link period before its next sample.
  assign link.misoOut = txSr_ff[LAST_BIT - bitCnt_ff];
  assign link.misoOe  = active;

  ////////////////////////////////////////////////////////////
  // Per-source message counters
  ////////////////////////////////////////////////////////////
  always_ff @(posedge link.sclk) begin
    if (rst) begin
      for (int i = 0; i < SRC_NUM; i++) begin
        msgCnt_ff[i] <= MSG_CNT_INIT;
      end
    end else if (fire && crcOk && isSensor && !noSample) begin
      msgCnt_ff[src] <= msgCnt_ff[src] + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////
  // Register command hand-off
  ////////////////////////////////////////////////////////////
  // Toggle event plus held fields: the user side syncs the toggle
  // and reads the fields, which stay put until the next command.
  logic       regReqTgl_ff;
  logic [3:0] regCmd_ff;
  logic [7:0] regAddr_ff;
  logic [7:0] regWr_ff;

  always_ff @(posedge link.sclk) begin
    if (rst) begin
      regReqTgl_ff <= 1'b0;
      regCmd_ff    <= CMD_NONE;
      regAddr_ff   <= 8'h00;
      regWr_ff     <= 8'h00;
    end else if (fire && crcOk && !isSensor) begin
      regReqTgl_ff <= ~regReqTgl_ff;
      regCmd_ff    <= cmd;
      regAddr_ff   <= rxWord[23:16];
      regWr_ff     <= rxWord[15:8];
    end
  end

  assign regReqTgl    = regReqTgl_ff;
  assign regCmd       = regCmd_ff;
  assign regAddrField = regAddr_ff;
  assign regWrData    = regWr_ff;

endmodule // scc_device_end
`default_nettype wire

// ==== design/scc_host_end.sv ====
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module scc_host_end
  import scc_pkg::*;
#(
  parameter int HALF = 4   // clk_sys cycles per link half period
) (
  input  wire logic              clk_sys,       // System clock
  input  wire logic              rst,           // Sync, active high
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,  // Write address
  input  wire logic              s_axi_awvalid, // Write address valid
  output logic                   s_axi_awready, // Write address ready
  input  wire logic [31:0]       s_axi_wdata,   // Write data
  input  wire logic [3:0]        s_axi_wstrb,   // Write strobes
  input  wire logic              s_axi_wvalid,  // Write data valid
  output logic                   s_axi_wready,  // Write data ready
  output logic [1:0]             s_axi_bresp,   // Write response
  output logic                   s_axi_bvalid,  // Write response valid
  input  wire logic              s_axi_bready,  // Write response ready
  input  wire logic [AXI_AW-1:0] s_axi_araddr,  // Read address
  input  wire logic              s_axi_arvalid, // Read address valid
  output logic                   s_axi_arready, // Read address ready
  output logic [31:0]            s_axi_rdata,   // Read data
  output logic [1:0]             s_axi_rresp,   // Read response
  output logic                   s_axi_rvalid,  // Read data valid
  input  wire logic              s_axi_rready,  // Read data ready
  scc_link_if.host               link           // Serial link
);

  ////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  ////////////////////////////////////////////////////////////
  logic              awHeld_ff;
  logic [AXI_AW-1:0] awAddr_ff;
  logic              wHeld_ff;
  logic [31:0]       wData_ff;
  logic [3:0]        wStrb_ff;
  logic              bvalid_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic              doWrite;
  logic [31:0]       rdMux;

  assign s_axi_awready = !awHeld_ff;
  assign s_axi_wready  = !wHeld_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = AXI_OKAY;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = AXI_OKAY;
  assign doWrite       = awHeld_ff && wHeld_ff && !bvalid_ff;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      wHeld_ff  <= 1'b0;
      wData_ff  <= '0;
      wStrb_ff  <= '0;
      bvalid_ff <= 1'b0;
    end else begin
      if (s_axi_awvalid && !awHeld_ff) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_ff <= 1'b0;
      end
      if (s_axi_wvalid && !wHeld_ff) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_ff <= 1'b0;
      end
      if (doWrite) begin
        bvalid_ff <= 1'b1;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Registers
  ////////////////////////////////////////////////////////////
  scc_state_t  state_ff;
  logic [2:0]  seed_ff;
  logic [28:0] cmdWord_ff;
  logic        startPend_ff;
  logic        done_ff;
  logic        rspOk_ff;
  logic [31:0] rsp_ff;
  logic        cmdWrite;
  logic        frameEnd;
  logic        busy;

  assign busy     = startPend_ff || (state_ff != SCC_IDLE);
  // A command written while busy is dropped
  assign cmdWrite = doWrite && (awAddr_ff == OFF_CMD) && (&wStrb_ff)
                    && !busy;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seed_ff    <= SEED_RST;
      cmdWord_ff <= '0;
    end else begin
      if (doWrite && (awAddr_ff == OFF_CTRL) && wStrb_ff[0]) begin
        seed_ff <= wData_ff[2:0];
      end
      if (cmdWrite) begin
        cmdWord_ff <= wData_ff[31:3];
      end
    end
  end

  // Frame end wins over the clear from a new command
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      done_ff <= 1'b0;
    end else if (frameEnd) begin
      done_ff <= 1'b1;
    end else if (cmdWrite) begin
      done_ff <= 1'b0;
    end
  end

  always_comb begin
    unique case (s_axi_araddr)
      OFF_CTRL: rdMux = {29'h0, seed_ff};
      OFF_CMD:  rdMux = {cmdWord_ff, CRC_ZERO};
      OFF_RSP:  rdMux = rsp_ff;
      OFF_STAT: rdMux = {29'h0, rspOk_ff, done_ff, busy};
      default:  rdMux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rdMux;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  // Link clock divider and frame engine
  ////////////////////////////////////////////////////////////
  logic [7:0]       divCnt_ff;
  logic             tick;
  logic             sclk_ff;
  logic             csN_ff;
  logic [31:0]      txSr_ff;
  logic [31:0]      rxSr_ff;
  logic [CNT_W-1:0] bitCnt_ff;
  logic             misoA_ff;
  logic             misoB_ff;

  assign tick     = (divCnt_ff == 8'(HALF - 1));
  assign frameEnd = (state_ff == SCC_GAP) && tick;

  // csN_ff is unknown only before the first reset edge; divider and
  // link clock load there and then run through the rest of reset.
  always_ff @(posedge clk_sys) begin
    if (!rst || csN_ff) begin
      if (tick) begin
        divCnt_ff <= '0;
      end else begin
        divCnt_ff <= divCnt_ff + 8'h1;
      end
    end else begin
      divCnt_ff <= '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    misoA_ff <= link.misoLine;
    misoB_ff <= misoA_ff;
  end

  // The link clock runs during reset so that the device end, which
  // lives on it, sees edges for its synchronous reset.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      if (csN_ff) begin
        if (tick) begin
          sclk_ff <= ~sclk_ff;
        end
      end else begin
        sclk_ff <= 1'b0;
      end
      csN_ff       <= 1'b1;
      state_ff     <= SCC_IDLE;
      startPend_ff <= 1'b0;
      txSr_ff      <= '0;
      rxSr_ff      <= '0;
      bitCnt_ff    <= '0;
      rsp_ff       <= '0;
      rspOk_ff     <= 1'b0;
    end else begin
      if (cmdWrite) begin
        startPend_ff <= 1'b1;
      end
      unique case (state_ff)
        SCC_IDLE: begin
          sclk_ff <= 1'b0;
          if (startPend_ff && tick) begin
            startPend_ff <= 1'b0;
            state_ff     <= SCC_SHIFT;
            csN_ff       <= 1'b0;
            bitCnt_ff    <= '0;
            txSr_ff      <= {cmdWord_ff,
                             crc3Word(seed_ff, {cmdWord_ff, CRC_ZERO})};
          end
        end
        SCC_SHIFT: begin
          if (tick && !sclk_ff) begin
            sclk_ff <= 1'b1;
            rxSr_ff <= {rxSr_ff[30:0], misoB_ff};
          end else if (tick) begin
            sclk_ff <= 1'b0;
            if (bitCnt_ff == LAST_BIT) begin
              csN_ff   <= 1'b1;
              state_ff <= SCC_GAP;
            end else begin
              txSr_ff   <= {txSr_ff[30:0], 1'b0};
              bitCnt_ff <= bitCnt_ff + 5'h1;
            end
          end
        end
        SCC_GAP: begin
          if (tick) begin
            state_ff <= SCC_IDLE;
            rsp_ff   <= rxSr_ff;
            rspOk_ff <= (crc3Word(seed_ff, rxSr_ff) == CRC_ZERO);
          end
        end
      endcase
    end
  end

  assign link.sclk = sclk_ff;
  assign link.csN  = csN_ff;
  assign link.mosi = txSr_ff[LAST_BIT];

endmodule // scc_host_end
`default_nettype wire

// ==== design/scc_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface scc_link_if;
  logic sclk;      // Link clock, made by the host
  logic csN;       // Frame select, active low
  logic mosi;      // Host to device data
  logic misoOut;   // Device data driver
  logic misoOe;    // Device drives the data line
  logic misoLine;  // Resolved line, pulled low when undriven

  assign misoLine = misoOe ? misoOut : 1'b0;

  modport dev (input sclk, csN, mosi, output misoOut, misoOe);
  modport host (output sclk, csN, mosi, input misoLine);
endinterface
`default_nettype wire

// ==== design/scc_pkg.sv ====
`default_nettype none
package scc_pkg;

  // Frame geometry
  localparam int          FRAME_BITS = 32;
  localparam int          CNT_W      = 5;
  localparam logic [4:0]  LAST_BIT   = 5'h1F;
  localparam int          CRC_BITS   = 3;

  // Polynomial x^3 + x + 1, taps below the top term
  localparam logic [2:0]  CRC_TAPS   = 3'h3;
  localparam logic [2:0]  CRC_ZERO   = 3'h0;

  // Command field
  localparam int          CMD_MSB    = 31;
  localparam int          CMD_LSB    = 28;
  localparam int          CMD_SENSOR = 0;   // C[0] set: sensor data request
  localparam int          SRC_W      = 3;

  // Coarse status codes
  localparam logic [1:0]  ST_INIT    = 2'h0;
  localparam logic [1:0]  ST_NORMAL  = 2'h1;
  localparam logic [1:0]  ST_SELF    = 2'h2;
  localparam logic [1:0]  ST_ERROR   = 2'h3;

  localparam logic [3:0]  CMD_NONE   = 4'h0;
  localparam logic [3:0]  MSG_CNT_INIT = 4'h1;
  localparam logic [31:0] RESP_RST   = 32'h0;

  // Host register map (AXI4-Lite byte addresses)
  localparam int          AXI_AW     = 4;
  localparam logic [3:0]  OFF_CTRL   = 4'h0;
  localparam logic [3:0]  OFF_CMD    = 4'h4;
  localparam logic [3:0]  OFF_RSP    = 4'h8;
  localparam logic [3:0]  OFF_STAT   = 4'hC;
  localparam logic [2:0]  SEED_RST   = 3'h7;
  localparam logic [1:0]  AXI_OKAY   = 2'h0;

  typedef enum logic [2:0] {
    SCC_IDLE  = 3'b001,
    SCC_SHIFT = 3'b010,
    SCC_GAP   = 3'b100
  } scc_state_t;

  function automatic logic [2:0] crc3Step(input logic [2:0] r,
                                          input logic       b);
    crc3Step = {r[1:0], b} ^ (r[2] ? CRC_TAPS : CRC_ZERO);
  endfunction

  // Whole 32-bit word, MSB first, register preset with the seed
  function automatic logic [2:0] crc3Word(input logic [2:0]  seed,
                                          input logic [31:0] w);
    logic [2:0] r;
    r = seed;
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      r = crc3Step(r, w[i]);
    end
    crc3Word = r;
  endfunction

  function automatic logic [1:0] coarseStatus(input logic initDone,
                                              input logic selfTest,
                                              input logic intErr);
    if (intErr) begin
      coarseStatus = ST_ERROR;
    end else if (selfTest) begin
      coarseStatus = ST_SELF;
    end else if (!initDone) begin
      coarseStatus = ST_INIT;
    end else begin
      coarseStatus = ST_NORMAL;
    end
  endfunction

endpackage
`default_nettype wire

// ==== test/scc_link_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module scc_link_properties #(
  parameter int HALF = 4  // clk_sys cycles per link half period
) (
  input wire logic clk_sys, // System clock
  input wire logic rst,     // Sync, active high
  input wire logic sclk,    // Link clock
  input wire logic csN,     // Frame select
  input wire logic mosi,    // Host data
  input wire logic misoOut, // Device data
  input wire logic misoOe   // Device drive enable
);
  localparam int SPAN = HALF;

  logic [5:0] riseCnt_ff;
  logic       sclkQ_ff;
  logic       csQ_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers: sclk is a clk_sys register, so sampling it here is clean
  always_ff @(posedge clk_sys) begin
    sclkQ_ff <= sclk;
    csQ_ff   <= csN;
  end

  always_ff @(posedge clk_sys) begin
    if (rst || (csQ_ff && !csN)) begin
      riseCnt_ff <= 6'h00;
    end else if (!csN && sclk && !sclkQ_ff) begin
      riseCnt_ff <= riseCnt_ff + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_oe_in_frame: assert property (csN |-> !misoOe)
    else $error("miso driven outside a frame");
  a_frame_bits: assert property (csN && !csQ_ff |-> riseCnt_ff == 6'h20)
    else $error("frame did not carry 32 clock pulses");
  a_mosi_steady: assert property (!csN && sclk && sclkQ_ff |-> $stable(mosi))
    else $error("mosi moved while sclk high");
  a_miso_after_rise: assert property (
    misoOe && $past(misoOe) && $changed(misoOut) |-> sclk)
    else $error("miso changed away from a rising edge");
  a_lead_time: assert property (
    $fell(csN) |-> !sclk [*3] ##[1:SPAN] sclk)
    else $error("first clock edge out of place after select");
  a_gap_length: assert property ($rose(csN) |-> csN [*8])
    else $error("frame gap too short");
  a_end_low: assert property ($rose(csN) |-> !sclk)
    else $error("frame ended with sclk high");
  a_high_phase: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("sclk high phase wrong");
  a_low_phase: assert property ($fell(sclk) && !csN |-> !sclk [*4])
    else $error("sclk low phase too short");

  c_frame_done: cover property ($rose(csN) && riseCnt_ff == 6'h20);
  c_dev_drives: cover property ($rose(misoOe));
  c_miso_moves: cover property (misoOe && $changed(misoOut));
endmodule // scc_link_properties
`default_nettype wire

// ==== test/spi_frame_crc3_codec_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module spi_frame_crc3_codec_tb;
  import scc_pkg::*;
  localparam int HALF = 4;

  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        crcSel = 1'b1, initDone = 1'b0, selfTest = 1'b0;
  logic        intErr = 1'b0, smpValid = 1'b0;
  logic [2:0]  seedDev = SEED_RST, seedHost = SEED_RST;
  logic [1:0]  detail = 2'h0;
  logic [15:0] sample = 16'h0, regRd = 16'h0;
  logic        regTgl, expTgl = 1'b0, skip = 1'b0;
  logic [3:0]  regCmd;
  logic [7:0]  regAddr, regWr;
  logic [31:0] rxMosi, rxMiso, prevAns = 32'h0, w, d, r;
  logic [3:0]  message_counter [8] = '{default: 4'h1};
  logic [23:0] tbl [7] = '{24'h822C14, 24'h41FC12, 24'hC22001, 24'h61FC10,
                           24'h4FF5A0, 24'hC3E005, 24'h6FF5A2};
  int          seed = 7, errorCnt = 0, nTests = 0, cyc = 0;

  always #20 clk_sys = ~clk_sys;

  scc_link_if lnk ();

  scc_host_end #(.HALF(HALF)) u_scc_host_end (
    .clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(lnk));

  scc_device_end u_scc_device_end (
    .link(lnk), .rst(rst), .crcSel(crcSel), .crcSeedField(seedDev),
    .initDoneFlag(initDone), .selfTestActive(selfTest),
    .internalError(intErr), .sampleValid(smpValid),
    .detailStatusField(detail), .sampleField(sample), .regRdData(regRd),
    .regReqTgl(regTgl), .regCmd(regCmd), .regAddrField(regAddr),
    .regWrData(regWr));

  scc_link_properties #(.HALF(HALF)) u_scc_link_properties (
    .clk_sys(clk_sys), .rst(rst), .sclk(lnk.sclk), .csN(lnk.csN),
    .mosi(lnk.mosi), .misoOut(lnk.misoOut), .misoOe(lnk.misoOe));

  ////////////////////////////////////////////////////////////////////////////
  // Wire watch: both lines are sampled at the rising link edge
  always @(posedge lnk.sclk) begin
    if (!lnk.csN) begin
      rxMosi <= {rxMosi[30:0], lnk.mosi};
      rxMiso <= {rxMiso[30:0], lnk.misoLine};
    end
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      errorCnt++;
      $display("ERROR timeout exp done got hang");
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (errorCnt == 0 && nTests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chkWord(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      errorCnt++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chkBit(input string nm, input logic e, input logic g);
    nTests++;
    if (g !== e) begin
      errorCnt++;
      $display("ERROR %s exp %b got %b", nm, e, g);
    end
  endtask

  task automatic axiWrite(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    while (!bvalid) @(posedge clk_sys);
    bready <= 1'b0;
    chkWord("bresp", 32'(AXI_OKAY), 32'(bresp));
  endtask

  task automatic axiRead(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (!rvalid);
    v = rdata;
    rready <= 1'b0;
    chkWord("rresp", 32'(AXI_OKAY), 32'(rresp));
  endtask

  // Second edge lets the new values land before the model reads them
  task automatic setIn(input logic [2:0] sd, input logic sel);
    logic [31:0] q;
    @(posedge clk_sys);
    r = $random(seed);
    q = $random(seed);
    initDone <= r[0] | r[1];
    selfTest <= &r[4:2];
    intErr <= &r[6:5];
    smpValid <= r[7];
    detail <= r[9:8];
    sample <= q[15:0];
    regRd <= q[31:16];
    seedDev <= sd;
    crcSel <= sel;
    @(posedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reference model
  function automatic logic [2:0] crcOf(input logic [2:0] s,
                                       input logic [31:0] v);
    logic [2:0] c;
    c = s;
    for (int i = 31; i >= 0; i--) begin
      c = {c[1:0], v[i]} ^ (c[2] ? 3'h3 : 3'h0);
    end
    return c;
  endfunction

  function automatic logic [1:0] stOf();
    return intErr ? 2'h3 : selfTest ? 2'h2 : !initDone ? 2'h0 : 2'h1;
  endfunction

  function automatic logic [31:0] ansOf(input logic [31:0] v, input logic ok);
    logic [31:0] a;
    logic [3:0]  c;
    c = v[31:28];
    if (!ok || (c[0] && intErr && !smpValid)) begin
      a = {4'h0, 2'h3, 16'h0, detail, 8'h00};
    end else if (c[0]) begin
      a = {c[0], c[3:1], stOf(), sample, detail, message_counter[c[3:1]], 4'h8};
      message_counter[c[3:1]] = message_counter[c[3:1]] + 4'h1;
    end else if (intErr) begin
      a = {4'h0, 2'h3, 2'h0, regRd, 8'h00};
    end else begin
      a = {c[0], c[3:1], stOf(), 2'h0, regRd, 8'h00};
    end
    return {a[31:3], crcOf(seedDev, a)};
  endfunction

  task automatic frame(input logic [31:0] v, input logic [3:0] ec);
    logic [31:0] full;
    logic [31:0] ans;
    logic        ok;
    full = {v[31:3], crcOf(seedHost, v)};
    ok = crcSel && crcOf(seedDev, full) == 3'h0;
    ans = crcSel ? ansOf(v, ok) : 32'h0;
    axiWrite(OFF_CMD, v);
    d = 32'h0;
    while (d[1] !== 1'b1) axiRead(OFF_STAT, d);
    chkWord("mosi word", full, rxMosi);
    if (ec[3]) chkWord("table crc", 32'(ec[2:0]), 32'(rxMosi[2:0]));
    if (!skip) begin
      axiRead(OFF_RSP, d);
      chkWord("answer", prevAns, d);
      chkWord("miso word", prevAns, rxMiso);
      axiRead(OFF_STAT, d);
      chkBit("answer ok", crcOf(seedHost, prevAns) == 3'h0, d[2]);
    end
    prevAns = ans;
    if (ok && !v[CMD_LSB]) begin
      expTgl = !expTgl;
      chkWord("reg fields", {12'h0, v[31:28], v[23:8]},
              {12'h0, regCmd, regAddr, regWr});
    end
    chkBit("reg toggle", expTgl, regTgl);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6 * HALF) @(posedge clk_sys);
    rst <= 1'b0;
    axiRead(OFF_CTRL, d);
    chkWord("ctrl reset", 32'(SEED_RST), 32'(d[2:0]));
    axiRead(OFF_STAT, d);
    chkWord("stat reset", 32'h0, 32'(d[1:0]));
    foreach (tbl[i]) begin
      setIn(SEED_RST, 1'b1);
      w = {tbl[i][23:20], 4'h0, tbl[i][19:4], 8'h00};
      frame(w, {1'b1, tbl[i][2:0]});
    end
    axiRead(OFF_CMD, d);
    chkWord("cmd readback", w, d);
    for (int i = 0; i < 40; i++) begin
      if (i == 20) begin
        axiWrite(OFF_CTRL, 32'h5);
        seedHost = 3'h5;
      end
      setIn(seedHost, 1'b1);
      r = $random(seed);
      w = r[28] ? {r[31:28], 28'h0} : {r[31:28], 4'h0, r[23:8], 8'h00};
      frame(w, 4'h0);
    end
    repeat (17) begin
      setIn(seedHost, 1'b1);
      frame(32'hB000_0000, 4'h0);
    end
    setIn(seedHost ^ 3'h2, 1'b1);
    frame(32'h4012_3400, 4'h0);
    setIn(seedHost, 1'b1);
    frame(32'h4012_3400, 4'h0);
    setIn(seedHost, 1'b0);
    skip = 1'b1;
    frame(32'h4012_3400, 4'h0);
    skip = 1'b0;
    frame(32'h4012_3400, 4'h0);
    conclude();
  end
endmodule // spi_frame_crc3_codec_tb
`default_nettype wire
